// ---- hdl/mtl_hist_bins.sv ----
// saturating histogram bin counters
module mtl_hist_bins (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // store port
    mtl_hist_if.store hist
);

    logic [15:0] bin_cnt_q [0:mtl_pkg::HIST_BINS-1];

    always_ff @(posedge sys_clk) begin
        if (!rstn || hist.clear) begin
            for (int i = 0; i < mtl_pkg::HIST_BINS; i++) begin
                bin_cnt_q[i] <= 16'h0000;
            end
        end else if (hist.inc && bin_cnt_q[hist.inc_bin] != mtl_pkg::BIN_MAX) begin
            bin_cnt_q[hist.inc_bin] <= bin_cnt_q[hist.inc_bin] + 16'h0001;
        end
    end

    // out-of-range index cannot occur after clamping, reads zero anyway
    assign hist.rd_count = (hist.rd_bin < 6'(mtl_pkg::HIST_BINS)) ? bin_cnt_q[hist.rd_bin]
                                                                   : 16'h0000;

    a_bin_saturate: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hist.inc && !hist.clear && bin_cnt_q[hist.inc_bin] == mtl_pkg::BIN_MAX
        |=> bin_cnt_q[$past(hist.inc_bin)] == mtl_pkg::BIN_MAX)
        else $error("full histogram bin changed");

    a_bin_count: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hist.inc && !hist.clear && bin_cnt_q[hist.inc_bin] != mtl_pkg::BIN_MAX
        |=> bin_cnt_q[$past(hist.inc_bin)] == $past(bin_cnt_q[hist.inc_bin]) + 16'h0001)
        else $error("histogram bin not incremented");

endmodule

// ---- hdl/mtl_hist_if.sv ----
// histogram store port between the logger core and its bin counters
interface mtl_hist_if;
    logic        clear;
    logic        inc;
    logic [5:0]  inc_bin;
    logic [5:0]  rd_bin;
    logic [15:0] rd_count;

    modport ctrl  (output clear, output inc, output inc_bin, output rd_bin, input rd_count);
    modport store (input clear, input inc, input inc_bin, input rd_bin, output rd_count);
endinterface

// ---- hdl/mtl_logger.sv ----
// mission temperature logger core with AHB-Lite register slave
module mtl_logger (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // conversion results
    input  wire logic        sample_valid,
    input  wire logic [7:0]  sample_code,
    input  wire logic        sample_below,
    input  wire logic        sample_above,
    // logger memory write port
    output logic             mem_we,
    output logic [12:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    // status
    output logic             mission_active_flag,
    output logic             high_temp_alarm_flag,
    output logic             low_temp_alarm_flag,
    output logic             logger_busy
);

    mtl_hist_if hist ();

    mtl_pkg::mtl_state_e state_q;
    logic        rollover_q;
    logic [7:0]  thr_low_q;
    logic [7:0]  thr_high_q;
    logic        active_q;
    logic        flag_high_q;
    logic        flag_low_q;
    logic [23:0] count_q;
    logic [10:0] ptr_q;
    logic [10:0] log_addr_q;
    logic        full_q;
    logic        log_en_q;
    logic [7:0]  code_q;
    logic [5:0]  bin_q;
    logic        side_q;
    logic [1:0]  byte_q;
    logic        mem_we_q;
    logic [12:0] mem_addr_q;
    logic [7:0]  mem_wdata_q;
    logic [31:0] hrdata_q;
    logic        wr_pend_q;
    logic [11:0] wr_idx_q;
    logic [31:0] rd_word;

    function automatic logic [11:0] word_index(input logic [31:0] a);
        word_index = (a[31:14] == 18'h00000) ? a[13:2] : mtl_pkg::IDX_NONE;
    endfunction

    function automatic logic [7:0] clamp_code(input logic [7:0] code,
                                              input logic below,
                                              input logic above);
        if (below) begin
            clamp_code = mtl_pkg::CODE_MIN;
        end else if (above || code > mtl_pkg::CODE_MAX) begin
            clamp_code = mtl_pkg::CODE_MAX;
        end else begin
            clamp_code = code;
        end
    endfunction

    function automatic logic [12:0] alarm_addr(input logic side,
                                               input logic [3:0] entry,
                                               input logic [1:0] byte_no);
        alarm_addr = (side ? mtl_pkg::ALM_HIGH_BASE : mtl_pkg::ALM_LOW_BASE)
                   + {7'h00, entry, byte_no};
    endfunction

    // bus side: zero wait states, always OKAY
    wire addr_ok   = hsel && htrans[1] && hready;
    wire wr_ctrl   = wr_pend_q && wr_idx_q == mtl_pkg::IDX_CTRL;
    wire wr_status = wr_pend_q && wr_idx_q == mtl_pkg::IDX_STATUS;
    wire start_cmd = wr_ctrl && hwdata[mtl_pkg::CTRL_START_BIT] && !active_q;
    wire stop_cmd  = wr_ctrl && hwdata[mtl_pkg::CTRL_STOP_BIT];
    wire clear_cmd = wr_ctrl && hwdata[mtl_pkg::CTRL_CLEAR_BIT];

    wire       accept    = sample_valid && active_q && state_q == mtl_pkg::ST_IDLE;
    wire [7:0] code_in   = clamp_code(sample_code, sample_below, sample_above);
    wire [1:0] side_hit  = {code_in >= thr_high_q, code_in <= thr_low_q};
    wire [1:0] alarm_set = side_hit & {2{accept}};

    wire [7:0]  side_idx_w;
    wire [15:0] side_dur_w;
    wire [3:0]  side_act_w;
    wire [3:0]  cur_idx = side_q ? side_idx_w[7:4] : side_idx_w[3:0];
    wire [7:0]  cur_dur = side_q ? side_dur_w[15:8] : side_dur_w[7:0];
    wire [1:0]  cur_act = side_q ? side_act_w[3:2] : side_act_w[1:0];

    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign hrdata               = hrdata_q;
    assign mem_we               = mem_we_q;
    assign mem_addr             = mem_addr_q;
    assign mem_wdata            = mem_wdata_q;
    assign mission_active_flag  = active_q;
    assign high_temp_alarm_flag = flag_high_q;
    assign low_temp_alarm_flag  = flag_low_q;
    assign logger_busy          = state_q != mtl_pkg::ST_IDLE;

    assign hist.clear   = clear_cmd;
    assign hist.inc     = accept;
    assign hist.inc_bin = code_in[7:2];
    assign hist.rd_bin  = bin_q;

    mtl_hist_bins u_bins (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .hist    (hist)
    );

    // address phase capture; hsize ignored, only words are used
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 12'h000;
            hrdata_q  <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_idx_q <= word_index(haddr);
            end
            if (addr_ok && !hwrite) begin
                hrdata_q <= rd_word;
            end
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (word_index(haddr))
            mtl_pkg::IDX_CTRL: begin
                rd_word[mtl_pkg::CTRL_ROLL_BIT] = rollover_q;
            end
            mtl_pkg::IDX_THR_LOW: begin
                rd_word[7:0] = thr_low_q;
            end
            mtl_pkg::IDX_THR_HIGH: begin
                rd_word[7:0] = thr_high_q;
            end
            mtl_pkg::IDX_STATUS: begin
                rd_word[mtl_pkg::STAT_HIGH_BIT]   = flag_high_q;
                rd_word[mtl_pkg::STAT_LOW_BIT]    = flag_low_q;
                rd_word[mtl_pkg::STAT_BUSY_BIT]   = state_q != mtl_pkg::ST_IDLE;
                rd_word[mtl_pkg::STAT_ACTIVE_BIT] = active_q;
            end
            mtl_pkg::IDX_COUNT: begin
                rd_word[23:0] = count_q;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // configuration, changed freely even mid-mission
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rollover_q <= mtl_pkg::ROLL_RST;
            thr_low_q  <= mtl_pkg::THR_LOW_RST;
            thr_high_q <= mtl_pkg::THR_HIGH_RST;
        end else begin
            if (wr_ctrl) begin
                rollover_q <= hwdata[mtl_pkg::CTRL_ROLL_BIT];
            end
            if (wr_pend_q && wr_idx_q == mtl_pkg::IDX_THR_LOW) begin
                thr_low_q <= hwdata[7:0];
            end
            if (wr_pend_q && wr_idx_q == mtl_pkg::IDX_THR_HIGH) begin
                thr_high_q <= hwdata[7:0];
            end
        end
    end

    // mission state and alarm flags
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            active_q    <= 1'b0;
            flag_high_q <= 1'b0;
            flag_low_q  <= 1'b0;
        end else begin
            if (start_cmd) begin
                active_q <= 1'b1;
            end else if (stop_cmd || (wr_status && !hwdata[mtl_pkg::STAT_ACTIVE_BIT])) begin
                active_q <= 1'b0;
            end
            // flag on alarm, set beats a same-cycle clear
            if (alarm_set[1]) begin
                flag_high_q <= 1'b1;
            end else if (wr_status && !hwdata[mtl_pkg::STAT_HIGH_BIT]) begin
                flag_high_q <= 1'b0;
            end
            if (alarm_set[0]) begin
                flag_low_q <= 1'b1;
            end else if (wr_status && !hwdata[mtl_pkg::STAT_LOW_BIT]) begin
                flag_low_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || clear_cmd) begin
            count_q <= 24'h000000;
        end else if (accept) begin
            count_q <= count_q + 24'h000001;
        end
    end

    // sample capture and datalog pointer
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            code_q     <= 8'h00;
            bin_q      <= 6'h00;
            log_addr_q <= 11'h000;
            log_en_q   <= 1'b0;
            ptr_q      <= 11'h000;
            full_q     <= 1'b0;
        end else if (start_cmd) begin
            ptr_q  <= 11'h000;
            full_q <= 1'b0;
        end else if (accept) begin
            code_q     <= code_in;
            bin_q      <= code_in[7:2];
            log_addr_q <= ptr_q;
            // stop when full, wrap when rolling over
            log_en_q   <= !full_q || rollover_q;
            if (!full_q || rollover_q) begin
                ptr_q <= ptr_q + 11'h001;
                if (ptr_q == mtl_pkg::DLOG_LAST) begin
                    full_q <= 1'b1;
                end
            end
        end
    end

    for (genvar s = 0; s < 2; s++) begin : g_side
        logic [3:0] idx_q;
        logic [7:0] dur_q;
        logic [1:0] act_q;
        logic       in_q;
        logic       rec_q;

        always_ff @(posedge sys_clk) begin
            if (!rstn || clear_cmd) begin
                idx_q <= 4'h0;
                dur_q <= 8'h00;
                act_q <= mtl_pkg::ACT_NONE;
                in_q  <= 1'b0;
                rec_q <= 1'b0;
            end else if (start_cmd) begin
                act_q <= mtl_pkg::ACT_NONE;
                in_q  <= 1'b0;
                rec_q <= 1'b0;
            end else if (accept) begin
                if (side_hit[s]) begin
                    in_q <= 1'b1;
                    // new entry on crossing or full duration
                    if (!in_q || dur_q == mtl_pkg::DUR_MAX) begin
                        dur_q <= 8'h01;
                        rec_q <= idx_q < mtl_pkg::ALM_ENTRIES;
                        if (idx_q < mtl_pkg::ALM_ENTRIES) begin
                            idx_q <= idx_q + 4'h1;
                            act_q <= mtl_pkg::ACT_OPEN;
                        end else begin
                            act_q <= mtl_pkg::ACT_NONE;
                        end
                    end else begin
                        dur_q <= dur_q + 8'h01;
                        act_q <= rec_q ? mtl_pkg::ACT_UPDATE : mtl_pkg::ACT_NONE;
                    end
                end else begin
                    in_q  <= 1'b0;
                    act_q <= mtl_pkg::ACT_NONE;
                end
            end
        end

        assign side_idx_w[4*s +: 4] = idx_q;
        assign side_dur_w[8*s +: 8] = dur_q;
        assign side_act_w[2*s +: 2] = act_q;
    end

    // write sequencer: one memory byte per cycle, samples refused while busy
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q     <= mtl_pkg::ST_IDLE;
            mem_we_q    <= 1'b0;
            mem_addr_q  <= 13'h0000;
            mem_wdata_q <= 8'h00;
            side_q      <= 1'b0;
            byte_q      <= 2'h0;
        end else begin
            mem_we_q <= 1'b0;
            case (state_q)
                mtl_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_q <= mtl_pkg::ST_LOG;
                    end
                end
                mtl_pkg::ST_LOG: begin
                    // datalog byte at base plus pointer
                    mem_we_q    <= log_en_q;
                    mem_addr_q  <= mtl_pkg::DLOG_BASE + {2'h0, log_addr_q};
                    mem_wdata_q <= code_q;
                    state_q     <= mtl_pkg::ST_HIST_LO;
                end
                mtl_pkg::ST_HIST_LO: begin
                    mem_we_q    <= 1'b1;
                    mem_addr_q  <= mtl_pkg::HIST_BASE + {6'h00, bin_q, 1'b0};
                    mem_wdata_q <= hist.rd_count[7:0];
                    state_q     <= mtl_pkg::ST_HIST_HI;
                end
                mtl_pkg::ST_HIST_HI: begin
                    mem_we_q    <= 1'b1;
                    mem_addr_q  <= mtl_pkg::HIST_BASE + {6'h00, bin_q, 1'b1};
                    mem_wdata_q <= hist.rd_count[15:8];
                    side_q      <= 1'b0;
                    byte_q      <= 2'h0;
                    state_q     <= mtl_pkg::ST_ALARM;
                end
                mtl_pkg::ST_ALARM: begin
                    // stamp bytes low first, duration last
                    if (cur_act == mtl_pkg::ACT_OPEN
                        || (cur_act == mtl_pkg::ACT_UPDATE && byte_q == 2'h3)) begin
                        mem_we_q    <= 1'b1;
                        mem_addr_q  <= alarm_addr(side_q, cur_idx - 4'h1, byte_q);
                        mem_wdata_q <= (byte_q == 2'h3) ? cur_dur
                                                        : count_q[{byte_q, 3'b000} +: 8];
                    end
                    byte_q <= byte_q + 2'h1;
                    if (byte_q == 2'h3) begin
                        side_q <= 1'b1;
                        if (side_q) begin
                            state_q <= mtl_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= mtl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_log_addr_seq: assert property (
        accept && (!full_q || rollover_q)
        |-> ##2 (mem_we_q && mem_addr_q == mtl_pkg::DLOG_BASE + {2'h0, $past(ptr_q, 2)}))
        else $error("datalog byte missing or misplaced");

    a_log_full_stop: assert property (
        accept && full_q && !rollover_q |-> ##2 !mem_we_q)
        else $error("datalog written after it filled");

    a_roll_wrap: assert property (
        accept && !start_cmd && (!full_q || rollover_q) && ptr_q == mtl_pkg::DLOG_LAST
        |=> ptr_q == 11'h000 && full_q)
        else $error("datalog pointer did not wrap");

    a_hist_low_byte: assert property (
        accept |-> ##3 (mem_we_q && mem_addr_q == mtl_pkg::HIST_BASE + {6'h00, bin_q, 1'b0}))
        else $error("histogram low byte not written");

    a_hist_high_byte: assert property (
        state_q == mtl_pkg::ST_HIST_HI |=> mem_we_q && mem_addr_q[0]
                                  && mem_wdata_q == $past(hist.rd_count[15:8]))
        else $error("histogram high byte wrong");

    a_code_clamped: assert property (
        accept |=> code_q <= mtl_pkg::CODE_MAX && bin_q == code_q[7:2])
        else $error("stored code out of range");

    a_band_quiet: assert property (
        accept && side_hit == 2'b00 && !clear_cmd && !start_cmd |=> side_act_w == 4'h0)
        else $error("alarm action inside band");

    a_flag_high: assert property (
        alarm_set[1] |=> flag_high_q ##1 (flag_high_q || $past(wr_status)))
        else $error("high flag not set on alarm");

    a_count_step: assert property (
        accept && !clear_cmd |=> count_q == $past(count_q) + 24'h000001)
        else $error("sample count did not step");

    a_idle_quiet: assert property (
        !active_q && state_q == mtl_pkg::ST_IDLE |=> !mem_we_q [*2])
        else $error("memory written outside mission");

endmodule

// ---- hdl/mtl_pkg.sv ----
// constants, encodings and register map of the mission temperature logger
package mtl_pkg;

    // logger memory map, byte addresses of the device memory
    localparam logic [12:0] DLOG_BASE     = 13'h1000;
    localparam logic [10:0] DLOG_LAST     = 11'h7FF;
    localparam logic [12:0] HIST_BASE     = 13'h0800;
    localparam int          HIST_BINS     = 63;
    localparam logic [15:0] BIN_MAX       = 16'hFFFF;
    localparam logic [12:0] ALM_LOW_BASE  = 13'h0220;
    localparam logic [12:0] ALM_HIGH_BASE = 13'h0250;
    localparam logic [3:0]  ALM_ENTRIES   = 4'hC;
    localparam logic [7:0]  DUR_MAX       = 8'hFF;

    // temperature code range
    localparam logic [7:0]  CODE_MIN      = 8'h00;
    localparam logic [7:0]  CODE_MAX      = 8'hFA;

    // register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_THR_HIGH  = 12'h20B;
    localparam logic [11:0] IDX_THR_LOW   = 12'h20C;
    localparam logic [11:0] IDX_CTRL      = 12'h20E;
    localparam logic [11:0] IDX_STATUS    = 12'h214;
    localparam logic [11:0] IDX_COUNT     = 12'h21A;
    localparam logic [11:0] IDX_NONE      = 12'hFFF;

    // control register fields
    localparam int CTRL_ROLL_BIT  = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_STOP_BIT  = 2;
    localparam int CTRL_CLEAR_BIT = 3;

    // status register fields
    localparam int STAT_HIGH_BIT   = 1;
    localparam int STAT_LOW_BIT    = 2;
    localparam int STAT_BUSY_BIT   = 4;
    localparam int STAT_ACTIVE_BIT = 5;

    // reset values
    localparam logic [7:0] THR_LOW_RST  = 8'h00;
    localparam logic [7:0] THR_HIGH_RST = 8'hFA;
    localparam logic       ROLL_RST     = 1'b0;

    // per-sample alarm action of one threshold
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_OPEN   = 2'h1;
    localparam logic [1:0] ACT_UPDATE = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOG,
        ST_HIST_LO,
        ST_HIST_HI,
        ST_ALARM
    } mtl_state_e;

endpackage

// ---- test/mtl_sample_src.sv ----
// converter model feeding one temperature result at a time
module mtl_sample_src (
    // clock
    input  wire logic       sys_clk,
    // conversion results
    output logic            sample_valid,
    output logic [7:0]      sample_code,
    output logic            sample_below,
    output logic            sample_above
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sample_valid = 1'b0;
        sample_code  = 8'h00;
        sample_below = 1'b0;
        sample_above = 1'b0;
    end
    // one-cycle result pulse; lines turn to junk once released
    task automatic send(input logic [7:0] c, input logic b, input logic a);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        sample_code  <= c;
        sample_below <= b;
        sample_above <= a;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        sample_code  <= ~c;
        sample_below <= ~b;
        sample_above <= ~a;
    endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench of the mission temperature logger
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic        hreadyout, hresp, mem_we, sv, sb, sa, act_f, hi_f, lo_f, busy;
    logic [31:0] hrdata;
    logic [12:0] mem_addr;
    logic [7:0]  mem_wdata, sc, thr[2];
    int          ptr, cnt, roll, error_cnt, compares, hist[63], ent[2], dur[2];
    bit          inx[2], ok[2], fl[2];
    logic [12:0] qa[$], ea;
    logic [7:0]  qd[$], ed;
    mtl_sample_src mtl_sample_src_inst (.sys_clk(sys_clk), .sample_valid(sv),
        .sample_code(sc), .sample_below(sb), .sample_above(sa));
    mtl_logger mtl_logger_inst (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sv),
        .sample_code(sc), .sample_below(sb), .sample_above(sa), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mission_active_flag(act_f),
        .high_temp_alarm_flag(hi_f), .low_temp_alarm_flag(lo_f), .logger_busy(busy));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic report_and_stop;
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {18'h0, idx, 2'h0};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic push(input logic [12:0] a, input logic [7:0] d);
        qa.push_back(a);
        qd.push_back(d);
    endtask
    task automatic model(input logic [7:0] c);
        logic [12:0] base;
        bit          hit;
        cnt++;
        if (ptr < 2048 || roll != 0) push(13'h1000 + 13'(ptr % 2048), c);
        ptr++;
        if (hist[c >> 2] < 65535) hist[c >> 2]++;
        push(13'h0800 + 13'(2 * (c >> 2)), 8'(hist[c >> 2]));
        push(13'h0801 + 13'(2 * (c >> 2)), 8'(hist[c >> 2] >> 8));
        for (int s = 0; s < 2; s++) begin
            base = (s == 1) ? 13'h0250 : 13'h0220;
            hit  = (s == 1) ? (c >= thr[1]) : (c <= thr[0]);
            if (hit) fl[s] = 1'b1;
            if (!hit) inx[s] = 1'b0;
            else if (!inx[s] || dur[s] == 255) begin
                inx[s] = 1'b1;
                dur[s] = 1;
                ok[s]  = ent[s] < 12;
                if (ok[s]) begin
                    for (int k = 0; k < 3; k++) push(base + 13'(4 * ent[s] + k), 8'(cnt >> (8 * k)));
                    push(base + 13'(4 * ent[s] + 3), 8'h01);
                    ent[s]++;
                end
            end else begin
                dur[s]++;
                if (ok[s]) push(base + 13'(4 * ent[s] - 1), 8'(dur[s]));
            end
        end
    endtask
    task automatic smp(input logic [7:0] raw, input logic b, input logic a, input bit on);
        mtl_sample_src_inst.send(raw, b, a);
        // clamp out-of-range codes before logging and binning
        if (on) model(b ? 8'h00 : (a || raw > 8'hFA) ? 8'hFA : raw);
        // one edge after acceptance the write sequence must be running
        @(posedge sys_clk);
        `CHK({busy, act_f}, {on, on})
        repeat (12) @(posedge sys_clk);
        `CHK(qa.size(), 0)
        `CHK({hi_f, lo_f}, {fl[1], fl[0]})
    endtask
    // memory writes must arrive in the predicted order
    always @(posedge sys_clk) if (mem_we === 1'b1) begin
        if (qa.size() == 0) `CHK(mem_we, 1'b0)
        else begin
            // pop once: the compare macro reads its expected value twice
            ea = qa.pop_front();
            ed = qd.pop_front();
            `CHK({mem_addr, mem_wdata}, {ea, ed})
        end
    end
    initial begin
        #8000000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(32'hB567));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(1'b0, mtl_pkg::IDX_THR_HIGH, 32'h0);
        `CHK(rd, 32'h0000_00FA)
        bus(1'b0, mtl_pkg::IDX_NONE, 32'h0);
        `CHK(rd, 32'h0)
        thr = '{8'h30, 8'hC0};
        bus(1'b1, mtl_pkg::IDX_THR_LOW, 32'h30);
        bus(1'b1, mtl_pkg::IDX_THR_HIGH, 32'hC0);
        for (int rr = 0; rr < 2; rr++) begin
            bus(1'b1, mtl_pkg::IDX_CTRL, 32'h8 + 32'(rr));
            bus(1'b1, mtl_pkg::IDX_CTRL, 32'h2 + 32'(rr));
            {ptr, cnt, roll} = {32'h0, 32'h0, 32'(rr)};
            ent = '{0, 0};
            inx = '{1'b0, 1'b0};
            hist = '{default: 0};
            for (int i = 0; i < 2050; i++) begin
                r = $urandom;
                // long hot spell forces duration rollover to a new entry
                if (rr == 0 && i < 300) r = 32'h0000_11E0;
                smp(r[7:0], r[11:8] == 4'h0, r[15:12] == 4'h0 && r[11:8] != 4'h0, 1'b1);
            end
            bus(1'b0, mtl_pkg::IDX_COUNT, 32'h0);
            `CHK(rd, 32'(cnt))
            bus(1'b0, mtl_pkg::IDX_STATUS, 32'h0);
            `CHK(rd, {26'h0, 3'b100, fl[0], fl[1], 1'b0})
            bus(1'b1, mtl_pkg::IDX_STATUS, 32'h0);
            fl = '{1'b0, 1'b0};
            smp(8'hFA, 1'b0, 1'b1, 1'b0);
            bus(1'b0, mtl_pkg::IDX_STATUS, 32'h0);
            `CHK(rd, 32'h0)
        end
        report_and_stop();
    end
endmodule
